/* acs_conversion_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_conversion_sequencer
    import acs_pkg::*;
#(
    parameter int WAKE_COUNT = WAKE_CYCLES,
    parameter int MOD_TICK_COUNT = MOD_TICK,
    parameter int MIC_HALF_COUNT = MIC_HALF
) (
    // clocks and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic CLK_LINK,
    // power and start control
    input wire logic CONVERTER_POWER_ON,
    input wire logic SOFTWARE_TRIGGER,
    input wire logic STOP_STROBE,
    // converter setup write
    input wire logic SETUP_WRITE,
    input wire logic [SETUP_W-1:0] SETUP_DATA,
    // calibration and offset control
    input wire logic CAL_ENABLE_SET,
    input wire logic CAL_DISABLE_STROBE,
    input wire logic AUTO_OFFSET_WRITE_ENABLE,
    input wire logic OFFSET_WRITE,
    input wire logic [DATA_W-1:0] OFFSET_DATA,
    // window comparator
    input wire logic WINDOW_COMPARE_ENABLE,
    input wire logic [DATA_W-1:0] UPPER_LIMIT,
    input wire logic [DATA_W-1:0] LOWER_LIMIT,
    // flag clear, one bit per flag
    input wire logic [FLAG_W-1:0] FLAG_CLEAR,
    // status and results
    output logic BUSY,
    output logic CALIBRATION_ENABLE,
    output logic CONVERSION_DONE_FLAG,
    output logic CALIBRATION_DONE_FLAG,
    output logic WINDOW_MATCH_FLAG,
    output logic [RESULT_W-1:0] CONVERSION_RESULT,
    output logic [DATA_W-1:0] OFFSET_VALUE,
    output logic [SETUP_W-1:0] SETUP_VALUE,
    // analog front end
    output logic ANALOG_POWER,
    output logic [SW_W-1:0] INPUT_SWITCHES,
    output logic [1:0] ATTEN_SELECT,
    output logic [1:0] BIAS_SELECT,
    input wire logic MOD_BIT,
    // microphone pins
    output logic MIC_BIT_CLOCK_PIN_O,
    output logic MIC_BIT_CLOCK_PIN_OE_N,
    input wire logic MIC_BITSTREAM_PIN
);
    acs_state_type state;
    acs_state_type next_state;
    logic [WAKE_W-1:0] wake_cnt;

    logic [SETUP_W-1:0] setup;
    logic cal_en;
    logic [DATA_W-1:0] offset;
    logic [DATA_W-1:0] acq_raw;
    logic [RESULT_W-1:0] result;

    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] flag_set;

    logic skip;
    logic done_hold;
    logic powered;

    logic [SW_W-1:0] switches;
    logic [1:0] tog_sync;
    logic tog_prev;

    // open code and the spare code 7 leave every switch open
    function automatic logic [SW_W-1:0] decode_channel(input logic [2:0] code);
        case (code)
            CH_SE_NEG: decode_channel = SWM_BIAS_P | SWM_NEG_PIN;
            CH_SE_POS: decode_channel = SWM_POS_PIN | SWM_BIAS_N;
            CH_DIFF: decode_channel = SWM_POS_PIN | SWM_NEG_PIN;
            CH_TEMP: decode_channel = SWM_BIAS_P | SWM_TEMP;
            CH_BATT: decode_channel = SWM_BIAS_P | SWM_BATT;
            CH_SHORT: decode_channel = SWM_BIAS_P | SWM_BIAS_N;
            default: decode_channel = '0;
        endcase
    endfunction

    acs_link_if link_bus();

    // filter and microphone logic on the link clock
    acs_pdm_filter #(
        .MOD_TICK_COUNT(MOD_TICK_COUNT),
        .MIC_HALF_COUNT(MIC_HALF_COUNT)
    ) u_filter (
        .clk_link(CLK_LINK),
        .resetn(RESETN),
        .link(link_bus),
        .mod_bit(MOD_BIT),
        .mic_data(MIC_BITSTREAM_PIN),
        .mic_clk(MIC_BIT_CLOCK_PIN_O),
        .mic_clk_oe_n(MIC_BIT_CLOCK_PIN_OE_N)
    );

    // setup fields
    wire [2:0] chan_code = setup[SF_CHAN +: 3];
    wire [1:0] osr_code = setup[SF_OSR +: 2];
    wire continuous_select = setup[SF_CONTINUOUS_SELECT];
    wire busy = state != ST_IDLE;

    // control towards the link side, steady while powered
    assign link_bus.run = powered;
    assign link_bus.osr_code = osr_code;
    assign link_bus.microphone_path_select = setup[SF_MIC];
    assign link_bus.halve = setup[SF_HALVE];

    // start, stop and repeat decisions
    wire start_req = CONVERTER_POWER_ON && SOFTWARE_TRIGGER && !done_hold;
    wire abort = STOP_STROBE || !CONVERTER_POWER_ON;
    wire repeat_conv = continuous_select && CONVERTER_POWER_ON && SOFTWARE_TRIGGER;
    wire wake_end = wake_cnt == WAKE_W'(WAKE_COUNT - 1);

    // frame arrival; the first edge after entering a phase is partial
    wire frame_edge = tog_sync[1] ^ tog_prev;
    wire frame_done = frame_edge && !skip;

    // filter scaling: (2*ones - ratio) * full scale / ratio
    wire signed [9:0] diff = $signed({1'b0, link_bus.frame_ones, 1'b0})
                           - $signed({2'b00, osr_value(osr_code)});
    wire signed [GAIN_W:0] gain_s = $signed({1'b0, osr_gain(osr_code)});
    wire signed [GAIN_W+10:0] product = diff * gain_s;
    wire [DATA_W-1:0] filt_raw = product[GAIN_SHIFT +: DATA_W];

    // result correction and window check
    wire use_cal = cal_en && AUTO_OFFSET_WRITE_ENABLE;
    wire [DATA_W-1:0] corrected = use_cal ? acq_raw - offset : acq_raw;
    wire win_hit = WINDOW_COMPARE_ENABLE
                && $signed(corrected) >= $signed(LOWER_LIMIT)
                && $signed(corrected) <= $signed(UPPER_LIMIT);

    wire cal_end = state == ST_CAL && frame_done;
    wire phase_entry = next_state != state && (next_state == ST_CAL || next_state == ST_ACQ);

    // events that set the sticky flags
    assign flag_set[FL_CONV] = state == ST_ELAB;
    assign flag_set[FL_CAL] = cal_end;
    assign flag_set[FL_WIN] = state == ST_ELAB && win_hit;

    // sequence: wake-up, calibration, acquisition, elaboration
    always_comb begin
        next_state = state;
        // an abort wins in every busy state
        if (busy && abort) begin
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        next_state = ST_WAKE;
                    end
                end

                ST_WAKE: begin
                    if (wake_end) begin
                        next_state = cal_en ? ST_CAL : ST_ACQ;
                    end
                end

                ST_CAL: begin
                    if (frame_done) begin
                        next_state = ST_ACQ;
                    end
                end

                ST_ACQ: begin
                    if (frame_done) begin
                        next_state = ST_ELAB;
                    end
                end

                ST_ELAB: begin
                    if (repeat_conv) begin
                        next_state = cal_en ? ST_CAL : ST_ACQ;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end

                default: next_state = ST_IDLE;
            endcase
        end
    end

    // state, power and wake-up counter
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            state <= ST_IDLE;
            powered <= 1'b0;
            wake_cnt <= '0;
        end else begin
            state <= next_state;
            powered <= next_state != ST_IDLE;
            wake_cnt <= state == ST_WAKE ? wake_cnt + 1'b1 : '0;
        end
    end

    // a single conversion or a stop waits for the trigger to drop
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            done_hold <= 1'b0;
        end else if ((state == ST_ELAB && !repeat_conv) || (busy && abort)) begin
            done_hold <= 1'b1;
        end else if (!SOFTWARE_TRIGGER) begin
            done_hold <= 1'b0;
        end
    end

    // frame toggle crossing; stage 0 feeds only stage 1
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            tog_sync <= 2'h0;
            tog_prev <= 1'b0;
        end else begin
            tog_sync <= {tog_sync[0], link_bus.frame_toggle};
            tog_prev <= tog_sync[1];
        end
    end

    // switches move at a phase change, so that frame is thrown away
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN || phase_entry) begin
            skip <= 1'b1;
        end else if (frame_edge) begin
            skip <= 1'b0;
        end
    end

    // setup is locked while a conversion runs
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            setup <= SETUP_RESET;
        end else if (SETUP_WRITE && !busy) begin
            setup <= SETUP_DATA;
        end
    end

    // calibration enable; the disable strobe wins over a set
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN || CAL_DISABLE_STROBE) begin
            cal_en <= 1'b0;
        end else if (CAL_ENABLE_SET) begin
            cal_en <= 1'b1;
        end
    end

    // offset: calibration result beats a manual write in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            offset <= '0;
        end else if (cal_end && AUTO_OFFSET_WRITE_ENABLE) begin
            offset <= filt_raw;
        end else if (OFFSET_WRITE) begin
            offset <= OFFSET_DATA;
        end
    end

    // acquired code, then the corrected result in the upper half
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            acq_raw <= '0;
            result <= '0;
        end else begin
            if (state == ST_ACQ && frame_done) begin
                acq_raw <= filt_raw;
            end

            if (state == ST_ELAB) begin
                result <= {corrected, {RAW_LSB{1'b0}}};
            end
        end
    end

    // sticky flags; a set in the clearing cycle survives
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~FLAG_CLEAR) | flag_set;
        end
    end

    // input switches follow the phase; calibration shorts the input
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN || next_state == ST_IDLE) begin
            switches <= '0;
        end else begin
            switches <= decode_channel(next_state == ST_CAL ? CH_SHORT : chan_code);
        end
    end

    // outputs
    assign BUSY = busy;
    assign CALIBRATION_ENABLE = cal_en;
    assign CONVERSION_DONE_FLAG = flags[FL_CONV];
    assign CALIBRATION_DONE_FLAG = flags[FL_CAL];
    assign WINDOW_MATCH_FLAG = flags[FL_WIN];

    assign CONVERSION_RESULT = result;
    assign OFFSET_VALUE = offset;
    assign SETUP_VALUE = setup;

    // front-end controls, all from flops
    assign ANALOG_POWER = powered;
    assign INPUT_SWITCHES = switches;
    assign ATTEN_SELECT = setup[SF_ATTEN +: 2];
    assign BIAS_SELECT = setup[SF_BIAS +: 2];
endmodule
`default_nettype wire

/* acs_pkg.sv */
`default_nettype none
package acs_pkg;
    // system clock and wake-up timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAKE_TIME_NS = 6000;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_W = 8;
    // link clock (6 ns) and the rates derived from it, in kHz
    localparam int LINK_CLK_KHZ = 166666;
    localparam int MOD_RATE_KHZ = 1000;
    localparam int MIC_FAST_KHZ = 1600;
    localparam int MOD_TICK = LINK_CLK_KHZ / MOD_RATE_KHZ;
    localparam int MIC_HALF = LINK_CLK_KHZ / (2 * MIC_FAST_KHZ);
    localparam int CNT_W = 8;
    // oversampling ratios per code
    localparam logic [7:0] OSR_0 = 8'hC8;
    localparam logic [7:0] OSR_1 = 8'h64;
    localparam logic [7:0] OSR_2 = 8'h40;
    localparam logic [7:0] OSR_3 = 8'h20;
    // full-scale factors and filter gains (full scale << shift / ratio)
    localparam int FS_LOW = 16708;
    localparam int FS_HIGH = 19450;
    localparam int GAIN_SHIFT = 16;
    localparam int GAIN_W = 26;
    localparam logic [GAIN_W-1:0] GAIN_0 = GAIN_W'((FS_HIGH << GAIN_SHIFT) / int'(OSR_0));
    localparam logic [GAIN_W-1:0] GAIN_1 = GAIN_W'((FS_HIGH << GAIN_SHIFT) / int'(OSR_1));
    localparam logic [GAIN_W-1:0] GAIN_2 = GAIN_W'((FS_LOW << GAIN_SHIFT) / int'(OSR_2));
    localparam logic [GAIN_W-1:0] GAIN_3 = GAIN_W'((FS_LOW << GAIN_SHIFT) / int'(OSR_3));
    // result layout
    localparam int DATA_W = 16;
    localparam int RESULT_W = 32;
    localparam int RAW_LSB = 16;
    // converter setup fields
    localparam int SETUP_W = 12;
    localparam int SF_CHAN = 0;
    localparam int SF_CONTINUOUS_SELECT = 3;
    localparam int SF_OSR = 4;
    localparam int SF_ATTEN = 6;
    localparam int SF_BIAS = 8;
    localparam int SF_MIC = 10;
    localparam int SF_HALVE = 11;
    localparam logic [SETUP_W-1:0] SETUP_RESET = 12'h000;
    // status flag positions
    localparam int FLAG_W = 3;
    localparam int FL_CONV = 0;
    localparam int FL_CAL = 1;
    localparam int FL_WIN = 2;
    // input channel codes
    localparam logic [2:0] CH_OPEN = 3'h0;
    localparam logic [2:0] CH_SE_NEG = 3'h1;
    localparam logic [2:0] CH_SE_POS = 3'h2;
    localparam logic [2:0] CH_DIFF = 3'h3;
    localparam logic [2:0] CH_TEMP = 3'h4;
    localparam logic [2:0] CH_BATT = 3'h5;
    localparam logic [2:0] CH_SHORT = 3'h6;
    // input switch masks
    localparam int SW_W = 6;
    localparam logic [SW_W-1:0] SWM_POS_PIN = 6'h01;
    localparam logic [SW_W-1:0] SWM_NEG_PIN = 6'h02;
    localparam logic [SW_W-1:0] SWM_BIAS_P = 6'h04;
    localparam logic [SW_W-1:0] SWM_BIAS_N = 6'h08;
    localparam logic [SW_W-1:0] SWM_TEMP = 6'h10;
    localparam logic [SW_W-1:0] SWM_BATT = 6'h20;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAKE = 3'h1,
        ST_CAL = 3'h3,
        ST_ACQ = 3'h2,
        ST_ELAB = 3'h6
    } acs_state_type;

    function automatic logic [7:0] osr_value(input logic [1:0] code);
        unique case (code)
            2'h0: osr_value = OSR_0;
            2'h1: osr_value = OSR_1;
            2'h2: osr_value = OSR_2;
            2'h3: osr_value = OSR_3;
        endcase
    endfunction

    function automatic logic [GAIN_W-1:0] osr_gain(input logic [1:0] code);
        unique case (code)
            2'h0: osr_gain = GAIN_0;
            2'h1: osr_gain = GAIN_1;
            2'h2: osr_gain = GAIN_2;
            2'h3: osr_gain = GAIN_3;
        endcase
    endfunction
endpackage
`default_nettype wire

/* acs_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface acs_link_if;
    logic run;
    logic [1:0] osr_code;
    logic microphone_path_select;
    logic halve;
    logic frame_toggle;
    logic [7:0] frame_ones;
    modport sys (output run, osr_code, microphone_path_select, halve, input frame_toggle, frame_ones);
    modport link (input run, osr_code, microphone_path_select, halve, output frame_toggle, frame_ones);
endinterface
`default_nettype wire

/* acs_pdm_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_pdm_filter
    import acs_pkg::*;
#(
    parameter int MOD_TICK_COUNT = MOD_TICK,
    parameter int MIC_HALF_COUNT = MIC_HALF
) (
    // link clock and system reset
    input wire logic clk_link,
    input wire logic resetn,
    // control in, frames out
    acs_link_if.link link,
    // modulator bit and microphone pins
    input wire logic mod_bit,
    input wire logic mic_data,
    output logic mic_clk,
    output logic mic_clk_oe_n
);
    logic [1:0] rst_sync;
    logic [1:0] run_sync;
    logic [1:0] mic_sync;
    logic [1:0] mod_sync;
    logic [1:0] osr_code;
    logic microphone_path_select;
    logic halve;
    logic [CNT_W-1:0] half_cnt;
    logic [CNT_W-1:0] tick_cnt;
    logic [7:0] sample_cnt;
    logic [7:0] ones;

    // two-stage synchronisers; only stage 1 reads stage 0
    always_ff @(posedge clk_link) begin
        rst_sync <= {rst_sync[0], resetn};
        run_sync <= {run_sync[0], link.run};
        mic_sync <= {mic_sync[0], mic_data};
        mod_sync <= {mod_sync[0], mod_bit};
    end

    wire rst_n = rst_sync[1];
    wire run = run_sync[1];
    wire bit_in = microphone_path_select ? mic_sync[1] : mod_sync[1];
    // slow clock doubles the half period
    wire [CNT_W-1:0] half_lim = halve ? CNT_W'(2 * MIC_HALF_COUNT - 1)
                                      : CNT_W'(MIC_HALF_COUNT - 1);
    wire half_end = half_cnt == half_lim;
    wire mic_rise = microphone_path_select && half_end && !mic_clk;
    wire mod_tick = !microphone_path_select && tick_cnt == CNT_W'(MOD_TICK_COUNT - 1);
    wire sample = run && (mic_rise || mod_tick);
    wire frame_end = sample && sample_cnt == osr_value(osr_code) - 8'h01;
    assign mic_clk_oe_n = !microphone_path_select;

    // setup is steady while the system side runs, so it is taken while idle
    always_ff @(posedge clk_link) begin
        if (!rst_n) begin
            osr_code <= 2'h0;
            microphone_path_select <= 1'b0;
            halve <= 1'b0;
        end else if (!run) begin
            osr_code <= link.osr_code;
            microphone_path_select <= link.microphone_path_select;
            halve <= link.halve;
        end
    end

    // microphone bit clock divider
    always_ff @(posedge clk_link) begin
        if (!rst_n || !run || !microphone_path_select) begin
            half_cnt <= '0;
            mic_clk <= 1'b0;
        end else begin
            half_cnt <= half_end ? '0 : half_cnt + 1'b1;
            if (half_end) begin
                mic_clk <= !mic_clk;
            end
        end
    end

    // modulator sample tick
    always_ff @(posedge clk_link) begin
        if (!rst_n || !run || mod_tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // decimating count of ones; the toggle marks each finished frame
    always_ff @(posedge clk_link) begin
        if (!rst_n) begin
            sample_cnt <= 8'h00;
            ones <= 8'h00;
            link.frame_toggle <= 1'b0;
            link.frame_ones <= 8'h00;
        end else if (!run || frame_end) begin
            sample_cnt <= 8'h00;
            ones <= 8'h00;
            if (frame_end) begin
                link.frame_ones <= ones + {7'h00, bit_in};
                link.frame_toggle <= !link.frame_toggle;
            end
        end else if (sample) begin
            sample_cnt <= sample_cnt + 8'h01;
            ones <= ones + {7'h00, bit_in};
        end
    end
endmodule
`default_nettype wire

/* acs_seq_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_seq_sva
    import acs_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // control inputs
    input wire logic CONVERTER_POWER_ON,
    input wire logic SOFTWARE_TRIGGER,
    input wire logic STOP_STROBE,
    input wire logic SETUP_WRITE,
    input wire logic [SETUP_W-1:0] SETUP_DATA,
    input wire logic CAL_DISABLE_STROBE,
    // design outputs
    input wire logic BUSY,
    input wire logic CALIBRATION_ENABLE,
    input wire logic CONVERSION_DONE_FLAG,
    input wire logic [RESULT_W-1:0] CONVERSION_RESULT,
    input wire logic [SETUP_W-1:0] SETUP_VALUE,
    input wire logic ANALOG_POWER,
    input wire logic [SW_W-1:0] INPUT_SWITCHES
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    // a fresh trigger with power on must start the sequence one cycle later
    a_start_busy: assert property (
        CONVERTER_POWER_ON && SOFTWARE_TRIGGER && !$past(SOFTWARE_TRIGGER) && !BUSY
        && !STOP_STROBE |=> BUSY && ANALOG_POWER) else $error("start lost");
    a_off_idle: assert property (
        !CONVERTER_POWER_ON |=> !BUSY && !ANALOG_POWER) else $error("runs unpowered");
    // setup word only moves on a write while idle
    a_setup_lock: assert property (
        BUSY |=> $stable(SETUP_VALUE)) else $error("setup moved while busy");
    a_setup_take: assert property (
        SETUP_WRITE && !BUSY |=> SETUP_VALUE == $past(SETUP_DATA)) else $error("setup lost");
    a_stop_abort: assert property (
        BUSY && STOP_STROBE |=> !BUSY && !ANALOG_POWER) else $error("stop ignored");
    a_cal_clear: assert property (
        CAL_DISABLE_STROBE |=> !CALIBRATION_ENABLE) else $error("calibration kept");
    a_raw_layout: assert property (
        CONVERSION_RESULT[15:0] == 16'h0000) else $error("low result half not zero");
    // done only rises as a conversion ends
    a_done_end: assert property (
        $rose(CONVERSION_DONE_FLAG) |-> $past(BUSY)) else $error("done outside conversion");
    a_idle_open: assert property (
        !BUSY && !$past(BUSY) |-> INPUT_SWITCHES == '0) else $error("switches closed idle");
endmodule

bind acs_conversion_sequencer acs_seq_sva chk (
    .CLK_SYS, .RESETN, .CONVERTER_POWER_ON, .SOFTWARE_TRIGGER, .STOP_STROBE, .SETUP_WRITE,
    .SETUP_DATA, .CAL_DISABLE_STROBE, .BUSY, .CALIBRATION_ENABLE, .CONVERSION_DONE_FLAG,
    .CONVERSION_RESULT, .SETUP_VALUE, .ANALOG_POWER, .INPUT_SWITCHES
);
`default_nettype wire

/* acs_front_model.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_front_model (
    // link clock and requested stream level
    input wire logic clk_link,
    input wire logic level,
    // device pins seen by the front end
    input wire logic power,
    input wire logic mic_oe_n,
    // streams into the device
    output logic mod_bit,
    output logic mic_data
);
    logic junk;
    // released lines wander so a stale value never passes for data
    always @(posedge clk_link) junk <= !(junk === 1'h1);
    // modulator streams only while the analog part is powered
    assign mod_bit = power ? level : junk;
    // microphone answers only while its clock pin is driven
    assign mic_data = mic_oe_n ? junk : level;
endmodule
`default_nettype wire

/* tb_adc_conversion_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_adc_conversion_sequencer
    import acs_pkg::*;
;
    logic CLK_SYS = '0, CLK_LINK = '0, RESETN = '0, lvl = '0, mprev = '0;
    logic CONVERTER_POWER_ON = '0, SOFTWARE_TRIGGER = '0, STOP_STROBE = '0, SETUP_WRITE = '0;
    logic CAL_ENABLE_SET = '0, CAL_DISABLE_STROBE = '0, AUTO_OFFSET_WRITE_ENABLE = '0;
    logic OFFSET_WRITE = '0, WINDOW_COMPARE_ENABLE = '0, MOD_BIT, MIC_BITSTREAM_PIN;
    logic [SETUP_W-1:0] SETUP_DATA = '0, SETUP_VALUE;
    logic [DATA_W-1:0] OFFSET_DATA = '0, UPPER_LIMIT = '0, LOWER_LIMIT = '0, OFFSET_VALUE, e;
    logic [FLAG_W-1:0] FLAG_CLEAR = '0;
    logic BUSY, CALIBRATION_ENABLE, CONVERSION_DONE_FLAG, CALIBRATION_DONE_FLAG;
    logic WINDOW_MATCH_FLAG, ANALOG_POWER, MIC_BIT_CLOCK_PIN_O, MIC_BIT_CLOCK_PIN_OE_N;
    logic [RESULT_W-1:0] CONVERSION_RESULT;
    logic [SW_W-1:0] INPUT_SWITCHES, sw_seen;
    logic [1:0] ATTEN_SELECT, BIAS_SELECT;
    int bad_count = 0, checks = 0, seed = 2, n = 0, mcnt = 0, mper = 0;

    // system clock, and a link clock offset so its edges drift against it
    always #50 CLK_SYS = ~CLK_SYS;
    always begin
        #1;
        forever #3 CLK_LINK = ~CLK_LINK;
    end

    acs_conversion_sequencer #(.MOD_TICK_COUNT(4), .MIC_HALF_COUNT(3)) uut (
        .CLK_SYS, .CLK_LINK, .RESETN, .CONVERTER_POWER_ON, .SOFTWARE_TRIGGER, .STOP_STROBE,
        .SETUP_WRITE, .SETUP_DATA, .CAL_ENABLE_SET, .CAL_DISABLE_STROBE,
        .AUTO_OFFSET_WRITE_ENABLE, .OFFSET_WRITE, .OFFSET_DATA, .WINDOW_COMPARE_ENABLE,
        .UPPER_LIMIT, .LOWER_LIMIT, .FLAG_CLEAR, .BUSY, .CALIBRATION_ENABLE,
        .CONVERSION_DONE_FLAG, .CALIBRATION_DONE_FLAG, .WINDOW_MATCH_FLAG, .CONVERSION_RESULT,
        .OFFSET_VALUE, .SETUP_VALUE, .ANALOG_POWER, .INPUT_SWITCHES, .ATTEN_SELECT,
        .BIAS_SELECT, .MOD_BIT, .MIC_BIT_CLOCK_PIN_O, .MIC_BIT_CLOCK_PIN_OE_N, .MIC_BITSTREAM_PIN
    );

    acs_front_model far (.clk_link(CLK_LINK), .level(lvl), .power(ANALOG_POWER),
        .mic_oe_n(MIC_BIT_CLOCK_PIN_OE_N), .mod_bit(MOD_BIT), .mic_data(MIC_BITSTREAM_PIN));

    // microphone clock period in link cycles, refreshed at each rising edge
    always @(posedge CLK_LINK) begin
        mprev <= MIC_BIT_CLOCK_PIN_O;
        mcnt <= (MIC_BIT_CLOCK_PIN_O && !mprev) ? 1 : mcnt + 1;
        if (MIC_BIT_CLOCK_PIN_O && !mprev) mper <= mcnt;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // bounded wait for the done flag; running out ends the run as a failure
    task automatic wait_done(input int lim);
        n = 0;
        while (CONVERSION_DONE_FLAG !== 1'h1 && n < lim) begin
            @(posedge CLK_SYS);
            n++;
        end
        if (n >= lim) begin
            bad_count++;
            test_done;
        end
    endtask

    // full-scale code for a constant stream: plus or minus the scale factor
    function automatic logic [15:0] code_of(input logic [1:0] r, input logic l);
        code_of = (r < 2'h2) ? 16'h4BFA : 16'h4144;
        if (!l) code_of = -code_of;
    endfunction

    function automatic logic [SW_W-1:0] sw_of(input logic [2:0] c);
        case (c)
            3'h1: sw_of = SWM_NEG_PIN | SWM_BIAS_P;
            3'h2: sw_of = SWM_POS_PIN | SWM_BIAS_N;
            3'h3: sw_of = SWM_POS_PIN | SWM_NEG_PIN;
            3'h4: sw_of = SWM_TEMP | SWM_BIAS_P;
            3'h5: sw_of = SWM_BATT | SWM_BIAS_P;
            3'h6: sw_of = SWM_BIAS_P | SWM_BIAS_N;
            default: sw_of = '0;
        endcase
    endfunction

    // one conversion: clear flags, set up, start, bounce a busy write, wait
    task automatic convert(input logic [11:0] sd, input logic l);
        @(posedge CLK_SYS);
        FLAG_CLEAR <= 3'h7;
        SOFTWARE_TRIGGER <= 1'h0;
        SETUP_WRITE <= 1'h1;
        SETUP_DATA <= sd;
        lvl <= l;
        @(posedge CLK_SYS);
        FLAG_CLEAR <= 3'h0;
        SETUP_WRITE <= 1'h0;
        CONVERTER_POWER_ON <= 1'h1;
        SOFTWARE_TRIGGER <= 1'h1;
        repeat (3) @(posedge CLK_SYS);
        SETUP_WRITE <= 1'h1;
        SETUP_DATA <= ~sd;
        @(posedge CLK_SYS);
        SETUP_WRITE <= 1'h0;
        repeat (55) @(posedge CLK_SYS);
        check(CONVERSION_DONE_FLAG, 1'h0);
        repeat (3) @(posedge CLK_SYS);
        sw_seen = INPUT_SWITCHES;
        wait_done(3000);
        check(SETUP_VALUE, sd);
    endtask

    initial begin
        repeat (2) @(posedge CLK_SYS);
        RESETN <= 1'h1;
        check({BUSY, ANALOG_POWER, CONVERSION_DONE_FLAG, CALIBRATION_DONE_FLAG,
            WINDOW_MATCH_FLAG, MIC_BIT_CLOCK_PIN_OE_N, OFFSET_VALUE}, 32'h10000);
        check(CONVERSION_RESULT, 32'h0);
        // every channel and ratio code, random level and limits, window forced once
        for (int c = 0; c < 7; c++) begin
            LOWER_LIMIT <= (c == 5) ? 16'h8000 : 16'($random(seed));
            UPPER_LIMIT <= (c == 5) ? 16'h7FFF : 16'($random(seed));
            WINDOW_COMPARE_ENABLE <= c[0];
            convert({4'h2, 2'(c % 3), 2'(c % 4), 1'h0, 3'(c)}, 1'($random(seed)));
            e = code_of(2'(c % 4), lvl);
            check(CONVERSION_RESULT, {e, 16'h0000});
            check(WINDOW_MATCH_FLAG, c[0] && $signed(LOWER_LIMIT) <= $signed(e)
                && $signed(e) <= $signed(UPPER_LIMIT));
            check(sw_seen, sw_of(3'(c)));
            check({ATTEN_SELECT, BIAS_SELECT}, {2'(c % 3), 2'h2});
            repeat (90) @(posedge CLK_SYS);
            check(BUSY, 1'h0);
        end
        // manual offset, then calibration without and with automatic update
        @(posedge CLK_SYS);
        OFFSET_WRITE <= 1'h1;
        OFFSET_DATA <= 16'($random(seed));
        CAL_ENABLE_SET <= 1'h1;
        @(posedge CLK_SYS);
        OFFSET_WRITE <= 1'h0;
        CAL_ENABLE_SET <= 1'h0;
        for (int a = 0; a < 2; a++) begin
            AUTO_OFFSET_WRITE_ENABLE <= a[0];
            convert(12'h206, 1'h1); // ratio 200 for a steady input
            check(OFFSET_VALUE, a ? 16'h4BFA : OFFSET_DATA);
            check(CONVERSION_RESULT[31:16], a ? 16'h0000 : 16'h4BFA);
            check({CALIBRATION_ENABLE, CALIBRATION_DONE_FLAG}, 2'h3);
        end
        @(posedge CLK_SYS);
        CAL_DISABLE_STROBE <= 1'h1;
        @(posedge CLK_SYS);
        CAL_DISABLE_STROBE <= 1'h0;
        AUTO_OFFSET_WRITE_ENABLE <= 1'h0;
        @(posedge CLK_SYS);
        check(CALIBRATION_ENABLE, 1'h0);
        // continuous run repeats until stopped
        convert(12'h23B, 1'h0);
        check(CONVERSION_RESULT[31:16], 16'hBEBC);
        FLAG_CLEAR <= 3'h1;
        @(posedge CLK_SYS);
        FLAG_CLEAR <= 3'h0;
        @(posedge CLK_SYS);
        wait_done(400);
        check(BUSY, 1'h1);
        STOP_STROBE <= 1'h1;
        @(posedge CLK_SYS);
        STOP_STROBE <= 1'h0;
        @(posedge CLK_SYS);
        check({BUSY, ANALOG_POWER}, 2'h0);
        // microphone path at both clock rates
        for (int h = 0; h < 2; h++) begin
            convert({h[0], 3'h6, 4'h1, 4'h0}, 1'h1);
            check(CONVERSION_RESULT[31:16], 16'h4BFA);
            check({MIC_BIT_CLOCK_PIN_OE_N, 8'(mper)}, {1'h0, 8'(6 << h)});
        end
        test_done;
    end
endmodule
`default_nettype wire
